/* design/lsbrg_defines.svh */
`ifndef LSBRG_DEFINES_SVH
`define LSBRG_DEFINES_SVH
// register byte offsets
`define LSBRG_PWR_OFS 8'h00
`define LSBRG_MODE_OFS 8'h04
`define LSBRG_RELOAD_OFS 8'h08
`define LSBRG_STATUS_OFS 8'h0C
// power_control_reg fields
`define LSBRG_DBL_BIT 0
// mode_ctrl_reg fields
`define LSBRG_MODE_LSB 0
`define LSBRG_SRC_EXT_BIT 2
`define LSBRG_CNT_EXT_BIT 3
`define LSBRG_RUN_BIT 4
// status_reg fields
`define LSBRG_ST_CNT_LSB 0
`define LSBRG_ST_HALF_BIT 8
`define LSBRG_ST_EVT_BIT 9
// reset values
`define LSBRG_DBL_RST 1'b0
`define LSBRG_MODE_RST 2'h0
`define LSBRG_RELOAD_RST 8'h00
`define LSBRG_RUN_RST 1'b0
// timing counts
`define LSBRG_OSC_DIV 12
`define LSBRG_SMP_PER_BIT 16
`define LSBRG_T1_TOP 8'hFF
`endif

/* design/lsbrg_pkg.sv */
`default_nettype none
package lsbrg_pkg;
   typedef enum logic [1:0] {
      LSBRG_MODE0 = 2'b00,
      LSBRG_MODE1 = 2'b01,
      LSBRG_MODE2 = 2'b10,
      LSBRG_MODE3 = 2'b11
   } lsbrg_mode_e;

   typedef struct packed {
      lsbrg_mode_e mode;
      logic rate_double_select;
      logic src_ext;
      logic cnt_ext;
      logic run;
      logic [7:0] timer1_reload_high;
   } lsbrg_cfg_s;

   typedef struct packed {
      lsbrg_cfg_s cfg;
      logic [7:0] t1_cnt;
      logic ovf;
      logic half;
      logic [1:0] osc_cnt;
      logic [2:0] ev_sync;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic ready;
      logic shift_en;
      logic sample_en;
   } lsbrg_state_s;
endpackage : lsbrg_pkg
`default_nettype wire

/* design/lsbrg_div.sv */
`default_nettype none
// counts enable pulses, emits one pulse on every DIV-th; clear restarts the count
module lsbrg_div #(
   parameter int WIDTH = 4,
   parameter int DIV = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clr,
   input wire logic en,
   output logic tick
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic tick;
   } lsbrg_div_s;

   localparam logic [WIDTH-1:0] LAST = WIDTH'(DIV - 1);

   lsbrg_div_s s_ff;
   lsbrg_div_s nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.tick = 1'b0;
      if (clr) begin
         nxt_s.cnt = '0;
      end else if (en) begin
         if (s_ff.cnt == LAST) begin
            nxt_s.cnt = '0;
            nxt_s.tick = 1'b1;
         end else begin
            nxt_s.cnt = s_ff.cnt + WIDTH'(1);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign tick = s_ff.tick;
endmodule : lsbrg_div
`default_nettype wire

/* design/lsbrg_top.sv */
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`include "lsbrg_defines.svh"
`default_nettype none
module lsbrg_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic t1_ovf_in,
   input wire logic t1_event_pin,
   input wire logic rx_align,
   output logic shift_en,
   output logic sample_en,
   output logic bit_en
);
   localparam lsbrg_pkg::lsbrg_state_s RST = '{
      cfg: '{mode: lsbrg_pkg::lsbrg_mode_e'(`LSBRG_MODE_RST), rate_double_select: `LSBRG_DBL_RST,
             src_ext: 1'b0, cnt_ext: 1'b0, run: `LSBRG_RUN_RST, timer1_reload_high: `LSBRG_RELOAD_RST},
      t1_cnt: 8'h00, ovf: 1'b0, half: 1'b0, osc_cnt: 2'h0, ev_sync: 3'h0, wr_pend: 1'b0,
      wr_addr: 8'h00, rdata: 32'h0000_0000, ready: 1'b1, shift_en: 1'b0, sample_en: 1'b0};

   lsbrg_pkg::lsbrg_state_s s_ff;
   lsbrg_pkg::lsbrg_state_s nxt_s;
   logic tick12;
   logic sel;
   logic ovf_src;
   logic ev_fall;
   logic t1_inc;

   // free-running oscillator over twelve, shared by mode 0 and the timer
   lsbrg_div #(.WIDTH(4), .DIV(`LSBRG_OSC_DIV)) u_osc12 (
      .hclk(hclk),
      .hresetn(hresetn),
      .clr(1'b0),
      .en(1'b1),
      .tick(tick12)
   );

   // sixteen sample states per bit, realigned by the receiver on a start edge
   lsbrg_div #(.WIDTH(4), .DIV(`LSBRG_SMP_PER_BIT)) u_bit16 (
      .hclk(hclk),
      .hresetn(hresetn),
      .clr(rx_align),
      .en(sel),
      .tick(bit_en)
   );

   always_comb begin
      nxt_s = s_ff;
      nxt_s.ev_sync = {s_ff.ev_sync[1:0], t1_event_pin};
      // edge taken from second and third stage only
      ev_fall = s_ff.ev_sync[2] & ~s_ff.ev_sync[1];
      // counter mode counts event falls, timer mode counts oscillator over twelve
      t1_inc = s_ff.cfg.run & (s_ff.cfg.cnt_ext ? ev_fall : tick12);
      nxt_s.ovf = 1'b0;
      if (t1_inc) begin
         if (s_ff.t1_cnt == `LSBRG_T1_TOP) begin
            nxt_s.t1_cnt = s_ff.cfg.timer1_reload_high;
            nxt_s.ovf = 1'b1;
         end else begin
            nxt_s.t1_cnt = s_ff.t1_cnt + 8'h01;
         end
      end
      // an external overflow covers the 13-bit and 16-bit timer modes run elsewhere
      ovf_src = s_ff.cfg.src_ext ? t1_ovf_in : s_ff.ovf;
      nxt_s.osc_cnt = s_ff.osc_cnt + 2'h1;
      sel = 1'b0;
      unique case (s_ff.cfg.mode)
         lsbrg_pkg::LSBRG_MODE0: begin
            sel = 1'b0;
         end
         lsbrg_pkg::LSBRG_MODE2: begin
            // sixteen samples per bit: oscillator over 2 or over 4
            sel = s_ff.cfg.rate_double_select ? s_ff.osc_cnt[0] : (s_ff.osc_cnt == 2'h3);
         end
         lsbrg_pkg::LSBRG_MODE1, lsbrg_pkg::LSBRG_MODE3: begin
            if (ovf_src) begin
               nxt_s.half = ~s_ff.half;
            end
            // sixteen samples per bit: every overflow, or every second one
            sel = ovf_src & (s_ff.cfg.rate_double_select | s_ff.half);
         end
      endcase
      nxt_s.sample_en = sel;
      nxt_s.shift_en = tick12 & (s_ff.cfg.mode == lsbrg_pkg::LSBRG_MODE0);
      // write data phase first, so a read right behind a write sees the new value
      nxt_s.wr_pend = 1'b0;
      if (s_ff.wr_pend) begin
         unique case (s_ff.wr_addr)
            `LSBRG_PWR_OFS: begin
               nxt_s.cfg.rate_double_select = hwdata[`LSBRG_DBL_BIT];
            end
            `LSBRG_MODE_OFS: begin
               nxt_s.cfg.mode = lsbrg_pkg::lsbrg_mode_e'(hwdata[`LSBRG_MODE_LSB +: 2]);
               nxt_s.cfg.src_ext = hwdata[`LSBRG_SRC_EXT_BIT];
               nxt_s.cfg.cnt_ext = hwdata[`LSBRG_CNT_EXT_BIT];
               nxt_s.cfg.run = hwdata[`LSBRG_RUN_BIT];
            end
            `LSBRG_RELOAD_OFS: begin
               nxt_s.cfg.timer1_reload_high = hwdata[7:0];
            end
            default: begin
               nxt_s.cfg = s_ff.cfg;
            end
         endcase
      end
      nxt_s.rdata = 32'h0000_0000;
      if (hsel && htrans[1] && hready) begin
         if (hwrite) begin
            nxt_s.wr_pend = 1'b1;
            nxt_s.wr_addr = haddr[7:0];
         end else begin
            unique case (haddr[7:0])
               `LSBRG_PWR_OFS: begin
                  nxt_s.rdata[`LSBRG_DBL_BIT] = nxt_s.cfg.rate_double_select;
               end
               `LSBRG_MODE_OFS: begin
                  nxt_s.rdata[`LSBRG_MODE_LSB +: 2] = nxt_s.cfg.mode;
                  nxt_s.rdata[`LSBRG_SRC_EXT_BIT] = nxt_s.cfg.src_ext;
                  nxt_s.rdata[`LSBRG_CNT_EXT_BIT] = nxt_s.cfg.cnt_ext;
                  nxt_s.rdata[`LSBRG_RUN_BIT] = nxt_s.cfg.run;
               end
               `LSBRG_RELOAD_OFS: begin
                  nxt_s.rdata[7:0] = nxt_s.cfg.timer1_reload_high;
               end
               `LSBRG_STATUS_OFS: begin
                  nxt_s.rdata[`LSBRG_ST_CNT_LSB +: 8] = s_ff.t1_cnt;
                  nxt_s.rdata[`LSBRG_ST_HALF_BIT] = s_ff.half;
                  nxt_s.rdata[`LSBRG_ST_EVT_BIT] = s_ff.ev_sync[2];
               end
               default: begin
                  nxt_s.rdata = 32'h0000_0000;
               end
            endcase
         end
      end
      nxt_s.ready = 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_ff <= RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // zero wait states, so hsize is not needed and every answer is OKAY
   assign hreadyout = s_ff.ready;
   assign hresp = 1'b0;
   assign hrdata = s_ff.rdata;
   assign shift_en = s_ff.shift_en;
   assign sample_en = s_ff.sample_en;

   // helper counters watched only by the checks below
   logic [3:0] gap_cnt_ff;
   logic gap_ok_ff;
   logic [3:0] smp_cnt_ff;
   logic smp_ok_ff;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_cnt_ff <= 4'h0;
         gap_ok_ff <= 1'b0;
         smp_cnt_ff <= 4'h0;
         smp_ok_ff <= 1'b0;
      end else begin
         gap_cnt_ff <= shift_en ? 4'h0 : gap_cnt_ff + 4'h1;
         gap_ok_ff <= shift_en ? 1'b1 : (gap_ok_ff & (gap_cnt_ff != 4'hF));
         if (rx_align) begin
            smp_cnt_ff <= 4'h0;
            smp_ok_ff <= 1'b0;
         end else if (bit_en) begin
            smp_cnt_ff <= 4'h0;
            smp_ok_ff <= 1'b1;
         end else if (sample_en) begin
            smp_cnt_ff <= smp_cnt_ff + 4'h1;
         end
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   wire cfg_wr = s_ff.wr_pend;

   sequence two_apart_s;
      ##1 !sample_en ##1 sample_en;
   endsequence

   sequence four_apart_s;
      ##1 !sample_en [*3] ##1 sample_en;
   endsequence

   mode0_shift_a: assert property (shift_en && gap_ok_ff |-> gap_cnt_ff == 4'hB)
      else $error("mode 0 shift spacing is not twelve");
   mode0_quiet_a: assert property (s_ff.cfg.mode == lsbrg_pkg::LSBRG_MODE0 && !$past(cfg_wr) |=> !sample_en)
      else $error("sample enable in mode 0");
   // a register write inside the window moves the rate, so such attempts are dropped
   mode2_fast_a: assert property (disable iff (!hresetn || cfg_wr)
      s_ff.cfg.mode == lsbrg_pkg::LSBRG_MODE2 && s_ff.cfg.rate_double_select && sample_en && !$past(cfg_wr)
      |-> two_apart_s)
      else $error("mode 2 doubled sample rate wrong");
   mode2_slow_a: assert property (disable iff (!hresetn || cfg_wr)
      s_ff.cfg.mode == lsbrg_pkg::LSBRG_MODE2 && !s_ff.cfg.rate_double_select && sample_en && !$past(cfg_wr)
      |-> four_apart_s)
      else $error("mode 2 sample rate wrong");
   timer_reload_a: assert property (s_ff.ovf |-> s_ff.t1_cnt == $past(s_ff.cfg.timer1_reload_high)
      && $past(s_ff.t1_cnt) == `LSBRG_T1_TOP)
      else $error("timer overflow without reload");
   ovf_sample_a: assert property ((s_ff.cfg.mode == lsbrg_pkg::LSBRG_MODE1 || s_ff.cfg.mode == lsbrg_pkg::LSBRG_MODE3)
      && s_ff.cfg.rate_double_select && ovf_src && !cfg_wr |=> sample_en)
      else $error("doubled overflow did not make a sample");
   ovf_half_a: assert property ((s_ff.cfg.mode == lsbrg_pkg::LSBRG_MODE1 || s_ff.cfg.mode == lsbrg_pkg::LSBRG_MODE3)
      && !s_ff.cfg.rate_double_select && ovf_src && !cfg_wr |=> sample_en == $past(s_ff.half))
      else $error("overflow halving wrong");
   bit_sixteen_a: assert property (bit_en && smp_ok_ff && sample_en |-> smp_cnt_ff == 4'hF)
      else $error("bit enable not on sixteenth sample");
   pulse_single_a: assert property (bit_en |-> sample_en ##1 !bit_en)
      else $error("bit enable not a single pulse");
endmodule : lsbrg_top
`default_nettype wire

/* verification/lsbrg_rx_model.sv */
`default_nettype none
// stands in for the serial port: counts the rate pulses and feeds the timer inputs
module lsbrg_rx_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clr,
   input wire logic shift_en,
   input wire logic sample_en,
   input wire logic bit_en,
   input wire logic [7:0] ovf_per,
   input wire logic [7:0] ev_per,
   output logic t1_ovf_in,
   output logic t1_event_pin,
   output logic [15:0] shift_cnt,
   output logic [15:0] samp_cnt,
   output logic [15:0] bit_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ov_ff;
   logic [7:0] ev_ff;
   // sources run free, so their phase never lines up with the count window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ov_ff <= 8'h0;
         ev_ff <= 8'h0;
         t1_ovf_in <= 1'b0;
         t1_event_pin <= 1'b1;
      end else begin
         ov_ff <= (ov_ff + 8'h1 >= ovf_per) ? 8'h0 : ov_ff + 8'h1;
         t1_ovf_in <= (ovf_per != 8'h0) && (ov_ff == 8'h0);
         ev_ff <= (ev_ff == (ev_per >> 1) - 8'h1) ? 8'h0 : ev_ff + 8'h1;
         if (ev_per != 8'h0 && ev_ff == (ev_per >> 1) - 8'h1) begin
            t1_event_pin <= ~t1_event_pin;
         end
      end
   end
   // a pulse held two cycles counts twice, so single-cycle pulses are checked too
   always_ff @(posedge hclk) begin
      shift_cnt <= clr ? 16'h0 : shift_cnt + {15'h0, shift_en};
      samp_cnt <= clr ? 16'h0 : samp_cnt + {15'h0, sample_en};
      bit_cnt <= clr ? 16'h0 : bit_cnt + {15'h0, bit_en};
   end
endmodule : lsbrg_rx_model
`default_nettype wire

/* verification/lsbrg_top_tb_top.sv */
`default_nettype none
module lsbrg_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] mode; logic [7:0] dbl; logic [7:0] rld; logic [7:0] ovf; logic [7:0] ev;
      logic [15:0] win; logic [15:0] sh; logic [15:0] sa; logic [15:0] bt;} lsbrg_row_s;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rx_align = 1'b0, clr = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] ovf_per = 8'h0, ev_per = 8'h0;
   logic hready, hreadyout, hresp, t1_ovf_in, t1_event_pin, shift_en, sample_en, bit_en;
   logic [15:0] shift_cnt, samp_cnt, bit_cnt;
   int err_count = 0, checked = 0;
   lsbrg_row_s rows [10] = '{
      '{8'h00, 8'h0, 8'h0, 8'h0, 8'h0, 16'h780, 16'hA0, 16'h0, 16'h0},
      '{8'h00, 8'h1, 8'h0, 8'h0, 8'h0, 16'h780, 16'hA0, 16'h0, 16'h0},
      '{8'h02, 8'h0, 8'h0, 8'h0, 8'h0, 16'h780, 16'h0, 16'h1E0, 16'h1E},
      '{8'h02, 8'h1, 8'h0, 8'h0, 8'h0, 16'h780, 16'h0, 16'h3C0, 16'h3C},
      '{8'h11, 8'h1, 8'hFF, 8'h0, 8'h0, 16'h780, 16'h0, 16'hA0, 16'hA},
      '{8'h11, 8'h0, 8'hFF, 8'h0, 8'h0, 16'h780, 16'h0, 16'h50, 16'h5},
      '{8'h13, 8'h0, 8'hFD, 8'h0, 8'h0, 16'h900, 16'h0, 16'h20, 16'h2},
      '{8'h13, 8'h1, 8'hFD, 8'h0, 8'h0, 16'h900, 16'h0, 16'h40, 16'h4},
      '{8'h05, 8'h1, 8'h0, 8'hA, 8'h0, 16'h780, 16'h0, 16'hC0, 16'hC},
      '{8'h19, 8'h1, 8'hFF, 8'h0, 8'h14, 16'h780, 16'h0, 16'h60, 16'h6}};
   assign hready = hreadyout;
   always #10 hclk = ~hclk;
   lsbrg_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .t1_ovf_in(t1_ovf_in), .t1_event_pin(t1_event_pin),
      .rx_align(rx_align), .shift_en(shift_en), .sample_en(sample_en), .bit_en(bit_en));
   lsbrg_rx_model i_rx (.hclk(hclk), .hresetn(hresetn), .clr(clr), .shift_en(shift_en),
      .sample_en(sample_en), .bit_en(bit_en), .ovf_per(ovf_per), .ev_per(ev_per), .t1_ovf_in(t1_ovf_in),
      .t1_event_pin(t1_event_pin), .shift_cnt(shift_cnt), .samp_cnt(samp_cnt), .bit_cnt(bit_cnt));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   // ready and read data are taken as the rising edge samples them, before the slave updates
   task automatic wait_rdy(output logic [31:0] rd);
      do begin
         @(posedge hclk);
      end while (hready !== 1'b1);
      rd = hrdata;
   endtask : wait_rdy
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      wait_rdy(rd);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy(rd);
   endtask : ahb
   initial begin
      repeat (90000) @(posedge hclk);
      err_count++;
      print_verdict();
   end
   initial begin
      logic [31:0] rd;
      int k;
      int kb;
      repeat (10) @(posedge hclk);
      chk({29'h0, shift_en, sample_en, bit_en}, 32'h0, "pulses in reset");
      hresetn <= 1'b1;
      foreach (rows[i]) begin
         ahb(1'b0, 8'h4 * i[7:0], 32'h0, rd);
         // the event pin idles high, so the synced copy in the status word reads one
         if (i < 5) chk(rd, (i == 3) ? 32'h200 : 32'h0, "reset or unmapped read");
      end
      ahb(1'b1, 8'h8, 32'hA5, rd);
      ahb(1'b0, 8'h8, 32'h0, rd);
      chk(rd, 32'hA5, "reload readback");
      $display("test registers done");
      foreach (rows[i]) begin
         ahb(1'b1, 8'h0, {24'h0, rows[i].dbl}, rd);
         ahb(1'b1, 8'h8, {24'h0, rows[i].rld}, rd);
         ahb(1'b1, 8'h4, {24'h0, rows[i].mode}, rd);
         ovf_per <= rows[i].ovf;
         ev_per <= rows[i].ev;
         repeat (3300) @(posedge hclk);
         clr <= 1'b1;
         @(posedge hclk);
         clr <= 1'b0;
         repeat (rows[i].win) @(posedge hclk);
         @(negedge hclk);
         chk({16'h0, shift_cnt}, {16'h0, rows[i].sh}, "shift count");
         chk({16'h0, samp_cnt}, {16'h0, rows[i].sa}, "sample count");
         chk({16'h0, bit_cnt}, {16'h0, rows[i].bt}, "bit count");
         $display("test row %0d done", i);
      end
      // realign mid-bit: the next bit pulse must come on the sixteenth sample
      ahb(1'b1, 8'h0, 32'h0, rd);
      ahb(1'b1, 8'h4, 32'h2, rd);
      do @(negedge hclk); while (sample_en !== 1'b1);
      @(posedge hclk);
      rx_align <= 1'b1;
      @(posedge hclk);
      rx_align <= 1'b0;
      k = 0;
      kb = 0;
      repeat (80) begin
         @(negedge hclk);
         if (sample_en === 1'b1) k++;
         if (bit_en === 1'b1 && kb == 0) kb = k;
      end
      chk(kb, 32'h10, "samples to realigned bit");
      $display("test align done");
      // reset in mid-run: pulses stop at once and the configuration falls back to mode 0
      @(posedge hclk);
      hresetn <= 1'b0;
      @(posedge hclk);
      @(negedge hclk);
      chk({28'h0, hreadyout, shift_en, sample_en, bit_en}, 32'h8, "outputs in mid-run reset");
      chk({31'h0, hresp}, 32'h0, "response in reset");
      chk(hrdata, 32'h0, "read data in reset");
      @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, 8'h4, 32'h0, rd);
      chk(rd, 32'h0, "mode after reset");
      ahb(1'b0, 8'h0, 32'h0, rd);
      chk(rd, 32'h0, "doubling after reset");
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      repeat (24) @(posedge hclk);
      @(negedge hclk);
      chk({16'h0, shift_cnt}, 32'h2, "shifts after reset");
      chk({16'h0, samp_cnt}, 32'h0, "samples after reset");
      $display("test reset done");
      print_verdict();
   end
endmodule : lsbrg_top_tb_top
`default_nettype wire
